// ### hw/ocm_sequencer.sv
// Ones' complement add, subtract, multiply and divide sequencer
`timescale 1ns/1ns

module ocm_sequencer (
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_b_i,
   // Command from instruction control
   input  wire logic                    start_i,
   input  wire ocm_pkg::ocm_op_type     op_i,
   input  wire ocm_pkg::ocm_load_type   load_i,
   // Status and results
   output logic                         busy_o,
   output logic                         done_o,
   output logic                         fault_o,
   output ocm_pkg::ocm_result_type      res_o
);

   // ***************************************************************
   // Ones' complement subtract with end-around carry
   // ***************************************************************
   // Adding Y is done as subtracting ~Y, so one path serves all.
   function automatic logic [71:0] oc_sub(input logic [71:0] a,
                                          input logic [71:0] b);
      logic [72:0] s;
      s = {1'b0, a} + {1'b0, ~b};
      return 72'(s[71:0] + {71'h0, s[72]});
   endfunction

   // ***************************************************************
   // Registers
   // ***************************************************************
   ocm_pkg::ocm_state_type state_q, state_d;
   ocm_pkg::ocm_op_type    op_q, op_d;
   logic [71:0]            acc_q, acc_d;
   logic [35:0]            mq_q, mq_d;
   logic [35:0]            x_q, x_d;
   logic [5:0]             cnt_q, cnt_d;
   logic                   neg_q, neg_d;     // Negative multiplier/dividend

   // ***************************************************************
   // Operand extensions and shifted accumulator
   // ***************************************************************
   logic [71:0] ext_d;      // Double-length extension D(X)
   logic [71:0] cpl_d;      // D(X') built from the complemented operand
   logic [71:0] ext_s;      // Split extension S(X)
   logic [71:0] a_rot1;
   logic [71:0] a_rot36;
   logic [71:0] q_ext;

   assign ext_d   = {{36{x_q[ocm_pkg::SGN_W]}}, x_q};
   assign cpl_d   = {{36{~x_q[ocm_pkg::SGN_W]}}, ~x_q};
   assign ext_s   = {ocm_pkg::WORD_ZERO, x_q};
   // Shifts are end-around, which is doubling in ones' complement
   assign a_rot1  = {acc_q[70:0], acc_q[ocm_pkg::SGN_A]};
   assign a_rot36 = {acc_q[ocm_pkg::HALF_SH-1:0],
                     acc_q[71:ocm_pkg::HALF_SH]};
   assign q_ext   = {{36{mq_q[ocm_pkg::SGN_W]}}, mq_q};

   // ***************************************************************
   // Arithmetic results, all through the one subtract form
   // ***************************************************************
   logic [71:0] add_x;      // A + D(X)
   logic [71:0] sub_x;      // A - D(X)
   logic [71:0] sadd_x;     // A + S(X)
   logic [71:0] ssub_x;     // A - S(X)
   logic [71:0] loop_add;   // 2A + D(X)
   logic [71:0] loop_sub;   // 2A - D(X)
   logic [71:0] q_dec;
   logic [71:0] q_inc;

   assign add_x    = oc_sub(acc_q, ~ext_d);
   assign sub_x    = oc_sub(acc_q, ~cpl_d);
   assign sadd_x   = oc_sub(acc_q, ~ext_s);
   assign ssub_x   = oc_sub(acc_q, ~(~ext_s));
   assign loop_add = oc_sub(a_rot1, ~ext_d);
   assign loop_sub = oc_sub(a_rot1, ~cpl_d);
   assign q_dec    = oc_sub(q_ext, ocm_pkg::ACC_ONE);
   assign q_inc    = oc_sub(q_ext, ~ocm_pkg::ACC_ONE);

   // ***************************************************************
   // Decisions
   // ***************************************************************
   logic        last_pass;
   logic        mul_ovf;
   logic        div_take;   // Residue and divisor agree in sign
   logic        res_neg;    // Sign of the partial remainder
   logic [71:0] div_base;   // Dividend after the negative-dividend step
   logic [71:0] div_start;  // Dividend turned by a half
   logic [71:0] div_acc;
   logic [35:0] div_mq;
   logic        div_ovf;
   logic        rem_neg;

   assign last_pass = (cnt_q == ocm_pkg::ITER_LAST);
   assign mul_ovf   = acc_q[ocm_pkg::OVF_HI] ^ acc_q[ocm_pkg::OVF_LO];
   // With A turned by a half, the remainder's sign sits at the top
   // of the low half; bit 71 holds a plain dividend bit there
   assign res_neg   = acc_q[ocm_pkg::HALF_SH-1];
   // Subtract when it shrinks the residue; Q0 records the choice
   assign div_take  = (res_neg == x_q[ocm_pkg::SGN_W]);
   // The divisor goes in at unit weight, so before the half turn
   assign div_base  = neg_q ? add_x : acc_q;
   assign div_start = {div_base[ocm_pkg::HALF_SH-1:0],
                       div_base[ocm_pkg::SGN_A:ocm_pkg::HALF_SH]};
   assign div_acc   = div_take ? loop_sub : loop_add;
   // Set Q0 then shift left end-around: the +-1 digits become the
   // ones' complement quotient once all passes are done
   assign div_mq    = {mq_q[34:1], div_take, mq_q[ocm_pkg::SGN_W]};
   // First pass must flip the residue sign, else the quotient would
   // exceed 2^35-1; a zero residue of either sign is accepted
   assign div_ovf   = (cnt_q == ocm_pkg::ITER_FIRST)
                    & (div_acc[ocm_pkg::HALF_SH-1] == res_neg)
                    & (div_acc != ocm_pkg::ACC_ZERO)
                    & (div_acc != ~ocm_pkg::ACC_ZERO);
   assign rem_neg   = acc_q[ocm_pkg::SGN_A] & (acc_q != ~ocm_pkg::ACC_ZERO);

   // ***************************************************************
   // Sequencer next state and datapath
   // ***************************************************************
   always_comb begin
      state_d = state_q;
      op_d    = op_q;
      acc_d   = acc_q;
      mq_d    = mq_q;
      x_d     = x_q;
      cnt_d   = cnt_q;
      neg_d   = neg_q;
      case (state_q)
         ocm_pkg::ST_IDLE: begin
            if (start_i) begin
               op_d    = op_i;
               acc_d   = load_i.acc;
               mq_d    = load_i.mq;
               x_d     = load_i.opnd;
               cnt_d   = ocm_pkg::ITER_FIRST;
               // Multiplier sign only; multiplicand sign is ignored
               neg_d   = load_i.mq[ocm_pkg::SGN_W];
               case (op_i)
                  ocm_pkg::OP_MUL:    state_d = ocm_pkg::ST_CHECK;
                  ocm_pkg::OP_MULACC: state_d = ocm_pkg::ST_PRESH;
                  ocm_pkg::OP_DIV: begin
                     neg_d   = load_i.acc[ocm_pkg::SGN_A];
                     state_d = ocm_pkg::ST_DINIT;
                  end
                  default:            state_d = ocm_pkg::ST_ARITH;
               endcase
            end
         end
         ocm_pkg::ST_ARITH: begin
            case (op_q)
               ocm_pkg::OP_SADD: acc_d = sadd_x;
               ocm_pkg::OP_SUB:  acc_d = sub_x;
               ocm_pkg::OP_SSUB: acc_d = ssub_x;
               default:          acc_d = add_x;
            endcase
            state_d = ocm_pkg::ST_DONE;
         end
         ocm_pkg::ST_PRESH: begin
            acc_d   = a_rot36;
            state_d = ocm_pkg::ST_CHECK;
         end
         ocm_pkg::ST_CHECK: begin
            if (mul_ovf) begin
               state_d = ocm_pkg::ST_FAULT;
            end else if (neg_q) begin
               state_d = ocm_pkg::ST_PRECOR;
            end else begin
               state_d = ocm_pkg::ST_MLOOP;
            end
         end
         ocm_pkg::ST_PRECOR: begin
            acc_d   = sub_x;
            state_d = ocm_pkg::ST_MLOOP;
         end
         ocm_pkg::ST_MLOOP: begin
            acc_d = mq_q[ocm_pkg::SGN_W] ? loop_add : a_rot1;
            mq_d  = {mq_q[34:0], 1'b0};
            cnt_d = 6'(cnt_q + 6'h01);
            if (last_pass) begin
               state_d = neg_q ? ocm_pkg::ST_POSTC : ocm_pkg::ST_DONE;
            end
         end
         ocm_pkg::ST_POSTC: begin
            acc_d   = add_x;
            state_d = ocm_pkg::ST_DONE;
         end
         ocm_pkg::ST_DINIT: begin
            // Negative dividend is moved one divisor further first
            acc_d   = div_start;
            mq_d    = ocm_pkg::WORD_ZERO;
            state_d = ocm_pkg::ST_DLOOP;
         end
         ocm_pkg::ST_DLOOP: begin
            if (div_ovf) begin
               state_d = ocm_pkg::ST_FAULT;
            end else begin
               acc_d = div_acc;
               mq_d  = div_mq;
               cnt_d = 6'(cnt_q + 6'h01);
               if (last_pass) begin
                  state_d = ocm_pkg::ST_DENDC;
               end
            end
         end
         ocm_pkg::ST_DENDC: begin
            if (neg_q) begin
               mq_d = q_dec[35:0];
            end
            state_d = ocm_pkg::ST_DFIX;
         end
         ocm_pkg::ST_DFIX: begin
            if (rem_neg) begin
               // Remainder gains |X|; quotient drops one for positive X, rises one for negative X
               acc_d = x_q[ocm_pkg::SGN_W] ? sub_x : add_x;
               mq_d  = x_q[ocm_pkg::SGN_W] ? q_inc[35:0]
                                           : q_dec[35:0];
            end
            state_d = ocm_pkg::ST_DONE;
         end
         ocm_pkg::ST_DONE: begin
            state_d = ocm_pkg::ST_IDLE;
         end
         ocm_pkg::ST_FAULT: begin
            state_d = ocm_pkg::ST_FAULT;
         end
         default: begin
            state_d = ocm_pkg::ST_IDLE;
         end
      endcase
   end

   // ***************************************************************
   // State registers
   // ***************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_q <= ocm_pkg::ST_IDLE;
         op_q    <= ocm_pkg::OP_ADD;
         acc_q   <= ocm_pkg::ACC_ZERO;
         mq_q    <= ocm_pkg::WORD_ZERO;
         x_q     <= ocm_pkg::WORD_ZERO;
         cnt_q   <= ocm_pkg::ITER_FIRST;
         neg_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q    <= op_d;
         acc_q   <= acc_d;
         mq_q    <= mq_d;
         x_q     <= x_d;
         cnt_q   <= cnt_d;
         neg_q   <= neg_d;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign busy_o    = (state_q != ocm_pkg::ST_IDLE);
   assign done_o    = (state_q == ocm_pkg::ST_DONE);
   assign fault_o   = (state_q == ocm_pkg::ST_FAULT);
   assign res_o.acc = acc_q;
   assign res_o.mq  = mq_q;

endmodule

// ### hw/ocm_pkg.sv
// Shared widths, counts, commands, states and carriers of the sequencer
package ocm_pkg;

   // ***************************************************************
   // Widths and counts
   // ***************************************************************
   localparam int          WORD_W   = 36;      // Operand and Q width
   localparam int          ACC_W    = 72;      // Accumulator width
   localparam int          CNT_W    = 6;
   localparam logic [5:0]  ITER_LAST = 6'h23;  // 36 passes, counted 0..35
   localparam logic [5:0]  ITER_FIRST = 6'h00;
   localparam int          HALF_SH  = 36;      // Pre-shift of A, in places
   localparam int          SGN_A    = 71;      // Sign bit of A
   localparam int          SGN_W    = 35;      // Sign bit of X and Q
   localparam int          OVF_HI   = 35;      // Bits compared before multiply
   localparam int          OVF_LO   = 34;
   localparam logic [71:0] ACC_ZERO = 72'h0;
   localparam logic [71:0] ACC_ONE  = 72'h1;
   localparam logic [35:0] WORD_ZERO = 36'h0;

   // ***************************************************************
   // Commands from instruction control
   // ***************************************************************
   typedef enum logic [2:0] {
      OP_ADD    = 3'h0,
      OP_SADD   = 3'h1,
      OP_SUB    = 3'h2,
      OP_SSUB   = 3'h3,
      OP_MUL    = 3'h4,
      OP_MULACC = 3'h5,
      OP_DIV    = 3'h6
   } ocm_op_type;

   // ***************************************************************
   // Sequencer states, one-hot
   // ***************************************************************
   typedef enum logic [12:0] {
      ST_IDLE   = 13'h0001,
      ST_ARITH  = 13'h0002,
      ST_PRESH  = 13'h0004,
      ST_CHECK  = 13'h0008,
      ST_PRECOR = 13'h0010,
      ST_MLOOP  = 13'h0020,
      ST_POSTC  = 13'h0040,
      ST_DINIT  = 13'h0080,
      ST_DLOOP  = 13'h0100,
      ST_DENDC  = 13'h0200,
      ST_DFIX   = 13'h0400,
      ST_DONE   = 13'h0800,
      ST_FAULT  = 13'h1000
   } ocm_state_type;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef struct packed {
      logic [71:0] acc;   // Accumulator load value
      logic [35:0] mq;    // Multiplier/quotient load value
      logic [35:0] opnd;  // Operand (X) load value
   } ocm_load_type;

   typedef struct packed {
      logic [71:0] acc;
      logic [35:0] mq;
   } ocm_result_type;

endpackage

// ### test/ocm_sequencer_monitor.sv
// Port-level concurrent checks for the ones' complement sequencer
`timescale 1ns/1ns
module ocm_sequencer_monitor (
   // Clock and reset
   input wire logic                    clk_i,
   input wire logic                    rst_b_i,
   // Command side
   input wire logic                    start_i,
   input wire ocm_pkg::ocm_op_type     op_i,
   input wire ocm_pkg::ocm_load_type   load_i,
   // Status and results
   input wire logic                    busy_o,
   input wire logic                    done_o,
   input wire logic                    fault_o,
   input wire ocm_pkg::ocm_result_type res_o
);
   // ***************************************************************
   // Helper logic
   // ***************************************************************
   // End-around carry sum, the ones' complement add
   function automatic logic [71:0] oc_add(logic [71:0] a, logic [71:0] b);
      logic [72:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[71:0] + {71'h0, s[72]};
   endfunction
   // Decodes of the command taken at this edge
   wire        take = start_i && !busy_o;
   wire        ovf  = load_i.acc[35] != load_i.acc[34];
   wire [71:0] sub_exp = oc_add(load_i.acc,
                                ~{{36{load_i.opnd[35]}}, load_i.opnd});
   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_sub_value: assert property (
      take && op_i == ocm_pkg::OP_SUB |->
      ##2 done_o && res_o.acc == $past(sub_exp, 2))
      else $error("subtract result wrong");
   a_arith_timing: assert property (
      take && op_i inside {ocm_pkg::OP_ADD, ocm_pkg::OP_SADD,
                           ocm_pkg::OP_SUB, ocm_pkg::OP_SSUB}
      |-> ##1 (busy_o && !done_o) ##1 done_o)
      else $error("add or subtract timing wrong");
   a_mul_timing: assert property (
      take && op_i == ocm_pkg::OP_MUL && !ovf && !load_i.mq[35]
      |-> ##38 done_o) else $error("multiply length wrong");
   a_mulneg_timing: assert property (
      take && op_i == ocm_pkg::OP_MUL && !ovf && load_i.mq[35]
      |-> ##40 done_o) else $error("corrected multiply length wrong");
   a_mul_fault: assert property (
      take && op_i == ocm_pkg::OP_MUL && ovf |-> ##[1:3] fault_o)
      else $error("multiply overflow not flagged");
   a_div_bound: assert property (
      take && op_i == ocm_pkg::OP_DIV |-> ##[1:40] (done_o || fault_o))
      else $error("divide did not finish");
   a_done_pulse: assert property (
      done_o |=> !done_o && !busy_o) else $error("done not one pulse");
   a_fault_hold: assert property (
      $rose(fault_o) |=> fault_o [*8]) else $error("fault dropped");
   a_fault_freeze: assert property (
      fault_o |=> $stable(res_o) && busy_o) else $error("result moved");
   a_idle_quiet: assert property (
      !busy_o |-> !done_o && !fault_o) else $error("status while idle");
   // Main scenarios reached
   c_mul_done: cover property (take && op_i == ocm_pkg::OP_MUL ##38 done_o);
   c_div_done: cover property (take && op_i == ocm_pkg::OP_DIV ##40 done_o);
   c_fault: cover property ($rose(fault_o));
endmodule

bind ocm_sequencer ocm_sequencer_monitor ocm_sequencer_monitor_inst (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .op_i(op_i),
   .load_i(load_i), .busy_o(busy_o), .done_o(done_o), .fault_o(fault_o),
   .res_o(res_o));

// ### test/ocm_icu_model.sv
// Instruction control model that issues commands to the sequencer
`timescale 1ns/1ns
module ocm_icu_model (
   // Clock
   input  wire logic             clk_i,
   // Sequencer status
   input  wire logic             busy_i,
   input  wire logic             done_i,
   input  wire logic             fault_i,
   // Command toward the sequencer
   output logic                  start_o,
   output ocm_pkg::ocm_op_type   op_o,
   output ocm_pkg::ocm_load_type load_o
);
   // Quiet bus at time zero
   initial begin
      start_o = 1'b0;
      op_o = ocm_pkg::OP_ADD;
      load_o = '0;
   end
   // One command; poke repeats start while busy, which must be ignored
   task automatic run(input ocm_pkg::ocm_op_type op,
                      input ocm_pkg::ocm_load_type ld, input int poke,
                      output int lat, output logic flt);
      int n;
      n = 0;
      // The cycle right after the take edge counts as cycle one
      lat = 1;
      flt = 1'b0;
      @(posedge clk_i);
      #1;
      while (busy_i !== 1'b0 && n < 60) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      @(posedge clk_i);
      start_o <= 1'b1;
      op_o <= op;
      load_o <= ld;
      @(posedge clk_i);
      // Load bus is no longer qualified, so it must not echo the word
      start_o <= 1'b0;
      load_o <= ~ld;
      while (lat < 60 && !flt) begin
         @(posedge clk_i);
         lat++;
         start_o <= (lat == poke);
         #1;
         if (done_i === 1'b1) break;
         flt = (fault_i === 1'b1);
      end
      if (n == 60) lat = 99;
   endtask
endmodule

// ### test/ocm_sequencer_tb.sv
// Self-checking bench for the ones' complement sequencer
`timescale 1ns/1ns
module ocm_sequencer_tb;
   typedef struct {
      ocm_pkg::ocm_op_type op;
      logic [71:0] a;
      logic [35:0] x, q;
      logic [71:0] ea;
      logic [35:0] eq;
      int          lat;
   } ocm_row_type;
   // ***************************************************************
   // Signals and instances
   // ***************************************************************
   logic                    clk, rst_b, start, busy, done, fault, flt;
   ocm_pkg::ocm_op_type     op;
   ocm_pkg::ocm_load_type   load;
   ocm_pkg::ocm_result_type res, snap;
   int                      err_count, tests_run, lat;
   ocm_row_type             rows[12];
   ocm_pkg::ocm_op_type     fop[3];
   logic [71:0]             fa[3];
   always #50 clk = ~clk;
   ocm_sequencer ocm_sequencer_inst (.clk_i(clk), .rst_b_i(rst_b),
      .start_i(start), .op_i(op), .load_i(load), .busy_o(busy),
      .done_o(done), .fault_o(fault), .res_o(res));
   ocm_icu_model ocm_icu_model_inst (.clk_i(clk), .busy_i(busy),
      .done_i(done), .fault_i(fault), .start_o(start), .op_o(op),
      .load_o(load));
   // ***************************************************************
   // Helpers
   // ***************************************************************
   // Signed value to ones' complement words
   function automatic logic [71:0] o72(longint v);
      return (v < 0) ? ~72'(-v) : 72'(v);
   endfunction
   function automatic logic [35:0] o36(longint v);
      return (v < 0) ? ~36'(-v) : 36'(v);
   endfunction
   task automatic chk_v(input logic [71:0] got, exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_n(input int got, exp, input string what);
      tests_run++;
      if (got != exp) begin
         err_count++;
         $display("BAD %0t %s took %0d not %0d", $time, what, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // A hung sequencer ends the run rather than stalling it
   task automatic issue(input ocm_pkg::ocm_op_type o, input logic [71:0] a,
                        input logic [35:0] x, q, input int poke);
      ocm_icu_model_inst.run(o, '{a, q, x}, poke, lat, flt);
      if (lat >= 60) begin
         err_count++;
         $display("BAD %0t no answer", $time);
         stop_test;
      end
   endtask
   task automatic do_reset;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk_v(72'({busy, done, fault}), 72'h0, "flags");
      chk_v(res.acc, 72'h0, "acc");
      chk_v(72'(res.mq), 72'h0, "q");
      @(posedge clk);
      rst_b <= 1'b1;
      $display("reset test done");
   endtask
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      err_count = 0;
      tests_run = 0;
      rows = '{
         '{ocm_pkg::OP_ADD, o72(6), o36(-3), 36'h0, o72(3), 36'h0, 2},
         '{ocm_pkg::OP_SADD, o72(6), 36'hf_ffff_fffc, 36'h0,
           o72(64'sh0000_000f_ffff_fffc + 6), 36'h0, 2},
         '{ocm_pkg::OP_SUB, o72(6), o36(-3), 36'h0, o72(9), 36'h0, 2},
         '{ocm_pkg::OP_SSUB, o72(6), 36'hf_ffff_fffc, 36'h0,
           o72(6 - 64'sh0000_000f_ffff_fffc), 36'h0, 2},
         '{ocm_pkg::OP_MUL, 72'h0, o36(3), o36(5), o72(15), 36'h0, 38},
         '{ocm_pkg::OP_MUL, 72'h0, o36(3), o36(-5), o72(-15), 36'h0, 40},
         '{ocm_pkg::OP_MUL, 72'h0, o36(-3), o36(5), o72(-15), 36'h0, 38},
         '{ocm_pkg::OP_MUL, 72'h0, o36(-3), o36(-5), o72(15), 36'h0, 40},
         '{ocm_pkg::OP_MULACC, o72(10), o36(3), o36(5), o72(25), 36'h0, 39},
         '{ocm_pkg::OP_DIV, o72(14), o36(4), 36'h0, o72(2), o36(3), 40},
         '{ocm_pkg::OP_DIV, o72(14), o36(-3), 36'h0, o72(2), o36(-4), 40},
         '{ocm_pkg::OP_DIV, o72(-22), o36(3), 36'h0, o72(2), o36(-8), 40}};
      fop = '{ocm_pkg::OP_MUL, ocm_pkg::OP_MULACC, ocm_pkg::OP_DIV};
      fa = '{72'h8_0000_0000, 72'h40_0000_0000_0000_0000,
             o72(64'sh100_0000_0000)};
      do_reset;
      // Table rows, issued back to back
      foreach (rows[i]) begin
         issue(rows[i].op, rows[i].a, rows[i].x, rows[i].q, 0);
         chk_v(res.acc, rows[i].ea, "acc");
         if (rows[i].op >= ocm_pkg::OP_MUL)
            chk_v(72'(res.mq), 72'(rows[i].eq), "q");
         if (rows[i].op == ocm_pkg::OP_DIV)
            chk_v(72'(lat >= 38 && lat <= 40), 72'h1, "div");
         else
            chk_n(lat, rows[i].lat, "length");
         $display("row %0d done", i);
      end
      // Start while busy must change nothing
      issue(ocm_pkg::OP_MUL, 72'h0, o36(3), o36(5), 5);
      chk_n(lat, 38, "ignored start");
      chk_v(res.acc, o72(15), "ignored start");
      $display("busy start test done");
      // Overflow faults freeze everything until reset
      for (int i = 0; i < 3; i++) begin
         issue(fop[i], fa[i], (i == 2) ? o36(1) : o36(3), o36(5), 0);
         chk_v(72'(flt), 72'h1, "fault");
         chk_v(72'(lat <= 3), 72'h1, "fault time");
         snap = res;
         repeat (8) @(posedge clk);
         #1;
         chk_v(72'({busy, fault}), 72'h3, "hold");
         chk_v(res.acc, snap.acc, "frozen");
         do_reset;
         $display("fault test %0d done", i);
      end
      stop_test;
   end
endmodule
